// ==== hw/tbsd_top.sv ====
// tbsd_top: tap controller, instruction decode, data registers, boundary
// pin control, part reset and cpu mailbox behind an axi4-lite slave.
// assumes tck/tms/tdi, pins and the reset pin are asynchronous inputs.
`timescale 1ns/1ps
module tbsd_top #(
  parameter int           PIN_N    = 28,
  parameter logic [3:0]   ID_VER   = 4'h0,   // first silicon revision
  parameter logic [15:0]  ID_PART  = 16'h5A5A, // arbitrary value
  parameter logic [10:0]  ID_MANUF = 11'h155,  // arbitrary value
  parameter int unsigned  TMO_FAST = tbsd_pkg::TMO_FAST_CYC,
  parameter int unsigned  TMO_SLOW = tbsd_pkg::TMO_SLOW_CYC
) (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  // axi4-lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output      logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output      logic                 s_axi_wready,
  output      logic [1:0]           s_axi_bresp,
  output      logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output      logic                 s_axi_arready,
  output      logic [31:0]          s_axi_rdata,
  output      logic [1:0]           s_axi_rresp,
  output      logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // tap pins
  input  wire tbsd_pkg::tbsd_tap_pins_t tap_i,
  output      logic                 tdo_o,
  output      logic                 tdo_oe_o,
  // fuses, locks, options
  input  wire logic                 tap_enable_fuse_i,
  input  wire logic                 lock_bit_one_i,
  input  wire logic                 lock_bit_two_i,
  input  wire logic                 clk_opt_slow_i,
  // part reset
  input  wire logic                 ext_rst_n_i,
  output      logic                 part_rst_o,
  // port pins
  input  wire logic [PIN_N-1:0]     pin_in_i,
  input  wire logic [PIN_N-1:0]     core_out_i,
  input  wire logic [PIN_N-1:0]     core_oe_i,
  output      logic [PIN_N-1:0]     pin_out_o,
  output      logic [PIN_N-1:0]     pin_oe_o,
  output      logic                 pullup_dis_o
);

  // ==========================================================
  // input synchronisers
  localparam int BS_W = 2 * PIN_N;
  localparam int DRW  = (BS_W > tbsd_pkg::ID_W) ? BS_W : tbsd_pkg::ID_W;
  localparam int IN_W = PIN_N + 4;

  logic [IN_W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic            tck_prev_reg;
  logic            tck_rise, tck_fall, tms, tdi, ext_rst_n;
  logic [PIN_N-1:0] pin_lvl;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_reg       <= '0;
      s2_reg       <= '0;
      s3_reg       <= '0;
      lvl_reg      <= '0;
      tck_prev_reg <= 1'b0;
    end else if (ce_i) begin
      s1_reg       <= {ext_rst_n_i, tap_i.tck, tap_i.tms, tap_i.tdi, pin_in_i};
      s2_reg       <= s1_reg;
      s3_reg       <= s2_reg;
      // a change counts only once stages two and three agree
      lvl_reg      <= (s2_reg & ~(s2_reg ^ s3_reg)) | (lvl_reg & (s2_reg ^ s3_reg));
      tck_prev_reg <= lvl_reg[PIN_N+2];
    end
  end

  assign ext_rst_n = lvl_reg[PIN_N+3];
  assign tms       = lvl_reg[PIN_N+1];
  assign tdi       = lvl_reg[PIN_N];
  assign pin_lvl   = lvl_reg[PIN_N-1:0];
  // tck is oversampled, so scan needs no core clock relation
  assign tck_rise  = ce_i & lvl_reg[PIN_N+2] & ~tck_prev_reg;
  assign tck_fall  = ce_i & ~lvl_reg[PIN_N+2] & tck_prev_reg;

  // ==========================================================
  // control registers
  logic       tap_dis_reg, dbg_fuse_reg, erased_reg, dbg_acc_reg;
  logic [7:0] mbx_data_reg, io_shared_reg;
  logic       dirty_reg;
  logic       tap_active, mbx_sel, locked;

  assign tap_active = tap_enable_fuse_i & ~tap_dis_reg;
  assign mbx_sel    = dbg_fuse_reg & dbg_acc_reg;
  assign locked     = lock_bit_one_i | lock_bit_two_i;

  // ==========================================================
  // tap controller
  tbsd_pkg::tbsd_state_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      tbsd_pkg::ST_TLR:    st_next = tms ? tbsd_pkg::ST_TLR    : tbsd_pkg::ST_RTI;
      tbsd_pkg::ST_RTI:    st_next = tms ? tbsd_pkg::ST_SEL_DR : tbsd_pkg::ST_RTI;
      tbsd_pkg::ST_SEL_DR: st_next = tms ? tbsd_pkg::ST_SEL_IR : tbsd_pkg::ST_CAP_DR;
      tbsd_pkg::ST_CAP_DR: st_next = tms ? tbsd_pkg::ST_EX1_DR : tbsd_pkg::ST_SH_DR;
      tbsd_pkg::ST_SH_DR:  st_next = tms ? tbsd_pkg::ST_EX1_DR : tbsd_pkg::ST_SH_DR;
      tbsd_pkg::ST_EX1_DR: st_next = tms ? tbsd_pkg::ST_UPD_DR : tbsd_pkg::ST_PA_DR;
      tbsd_pkg::ST_PA_DR:  st_next = tms ? tbsd_pkg::ST_EX2_DR : tbsd_pkg::ST_PA_DR;
      tbsd_pkg::ST_EX2_DR: st_next = tms ? tbsd_pkg::ST_UPD_DR : tbsd_pkg::ST_SH_DR;
      tbsd_pkg::ST_UPD_DR: st_next = tms ? tbsd_pkg::ST_SEL_DR : tbsd_pkg::ST_RTI;
      tbsd_pkg::ST_SEL_IR: st_next = tms ? tbsd_pkg::ST_TLR    : tbsd_pkg::ST_CAP_IR;
      tbsd_pkg::ST_CAP_IR: st_next = tms ? tbsd_pkg::ST_EX1_IR : tbsd_pkg::ST_SH_IR;
      tbsd_pkg::ST_SH_IR:  st_next = tms ? tbsd_pkg::ST_EX1_IR : tbsd_pkg::ST_SH_IR;
      tbsd_pkg::ST_EX1_IR: st_next = tms ? tbsd_pkg::ST_UPD_IR : tbsd_pkg::ST_PA_IR;
      tbsd_pkg::ST_PA_IR:  st_next = tms ? tbsd_pkg::ST_EX2_IR : tbsd_pkg::ST_PA_IR;
      tbsd_pkg::ST_EX2_IR: st_next = tms ? tbsd_pkg::ST_UPD_IR : tbsd_pkg::ST_SH_IR;
      tbsd_pkg::ST_UPD_IR: st_next = tms ? tbsd_pkg::ST_SEL_DR : tbsd_pkg::ST_RTI;
      default:             st_next = tbsd_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= tbsd_pkg::ST_TLR;
    end else if (ce_i) begin
      if (!tap_active) begin
        st_reg <= tbsd_pkg::ST_TLR;
      end else if (tck_rise) begin
        st_reg <= st_next;
      end
    end
  end

  // ==========================================================
  // instruction register
  logic [3:0] ir_reg, ir_sh_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_reg    <= tbsd_pkg::OP_IDCODE;
      ir_sh_reg <= '0;
    end else if (ce_i) begin
      if (st_reg == tbsd_pkg::ST_TLR) begin
        ir_reg <= tbsd_pkg::OP_IDCODE;
      end else if (tck_rise) begin
        case (st_reg)
          tbsd_pkg::ST_CAP_IR: ir_sh_reg <= tbsd_pkg::IR_CAPTURE;
          tbsd_pkg::ST_SH_IR:  ir_sh_reg <= {tdi, ir_sh_reg[3:1]};
          tbsd_pkg::ST_UPD_IR: ir_reg    <= ir_sh_reg;
          default:             ir_sh_reg <= ir_sh_reg;
        endcase
      end
    end
  end

  // ==========================================================
  // data register select and capture
  int              sel_len;
  logic [DRW-1:0]  dr_sh_reg, dr_cap, dr_shifted;
  logic [BS_W-1:0] upd_reg;
  logic            rst_bit_reg;
  tbsd_pkg::tbsd_idcode_t id_word;

  assign id_word = '{version: ID_VER, part: ID_PART, manuf: ID_MANUF, one: 1'b1};

  always_comb begin
    sel_len = 1;
    dr_cap  = '0;
    case (ir_reg)
      tbsd_pkg::OP_EXTEST, tbsd_pkg::OP_SAMPLE: begin
        sel_len = BS_W;
        for (int i = 0; i < PIN_N; i++) begin
          dr_cap[2*i]   = core_oe_i[i];
          dr_cap[2*i+1] = pin_lvl[i];
        end
      end
      tbsd_pkg::OP_IDCODE: begin
        sel_len                   = tbsd_pkg::ID_W;
        dr_cap[tbsd_pkg::ID_W-1:0] = id_word;
      end
      tbsd_pkg::OP_MBX: begin
        sel_len                     = tbsd_pkg::MBX_W;
        dr_cap[tbsd_pkg::MBX_W-1:0] = {dirty_reg, mbx_data_reg};
      end
      tbsd_pkg::OP_DBGACC: begin
        dr_cap[0] = dbg_acc_reg;
      end
      default: begin
        sel_len = 1;
      end
    endcase
  end

  always_comb begin
    dr_shifted              = {1'b0, dr_sh_reg[DRW-1:1]};
    dr_shifted[sel_len - 1] = tdi;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dr_sh_reg <= '0;
    end else if (ce_i && tck_rise) begin
      if (st_reg == tbsd_pkg::ST_CAP_DR) begin
        dr_sh_reg <= dr_cap;
      end else if (st_reg == tbsd_pkg::ST_SH_DR) begin
        dr_sh_reg <= dr_shifted;
      end
    end
  end

  // boundary update latches; loaded under both scan opcodes
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_reg <= '0;
    end else if (ce_i && tck_rise && st_reg == tbsd_pkg::ST_UPD_DR) begin
      if (ir_reg == tbsd_pkg::OP_EXTEST || ir_reg == tbsd_pkg::OP_SAMPLE) begin
        upd_reg <= dr_sh_reg[BS_W-1:0];
      end
    end
  end

  // reset bit is its own shift stage, no capture and no latch
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_bit_reg <= 1'b0;
    end else if (ce_i) begin
      if (st_reg == tbsd_pkg::ST_TLR) begin
        rst_bit_reg <= 1'b0;
      end else if (tck_rise && st_reg == tbsd_pkg::ST_SH_DR && ir_reg == tbsd_pkg::OP_RESET) begin
        rst_bit_reg <= tdi;
      end
    end
  end

  // ==========================================================
  // serial output, changes on tck falling edge
  logic tdo_reg, tdo_oe_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (ce_i) begin
      if (!tap_active) begin
        tdo_oe_reg <= 1'b0;
      end else if (tck_fall) begin
        tdo_oe_reg <= (st_reg == tbsd_pkg::ST_SH_DR) || (st_reg == tbsd_pkg::ST_SH_IR);
        if (st_reg == tbsd_pkg::ST_SH_IR) begin
          tdo_reg <= ir_sh_reg[0];
        end else if (ir_reg == tbsd_pkg::OP_RESET) begin
          tdo_reg <= rst_bit_reg;
        end else begin
          tdo_reg <= dr_sh_reg[0];
        end
      end
    end
  end

  assign tdo_o    = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;

  // ==========================================================
  // part reset and time-out
  logic [31:0] tmo_reg;
  logic        rst_src;

  assign rst_src    = rst_bit_reg | ~ext_rst_n;
  assign part_rst_o = rst_src | (tmo_reg != 32'h0);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmo_reg <= '0;
    end else if (ce_i) begin
      if (rst_src) begin
        tmo_reg <= clk_opt_slow_i ? TMO_SLOW : TMO_FAST;
      end else if (tmo_reg != 32'h0) begin
        tmo_reg <= tmo_reg - 32'h1;
      end
    end
  end

  // ==========================================================
  // pin drive
  logic [PIN_N-1:0] pout_reg, poe_reg;
  logic             pud_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pout_reg <= '0;
      poe_reg  <= '0;
      pud_reg  <= 1'b0;
    end else if (ce_i) begin
      pud_reg <= (ir_reg == tbsd_pkg::OP_EXTEST) || (ir_reg == tbsd_pkg::OP_SAMPLE);
      for (int i = 0; i < PIN_N; i++) begin
        // sample_preload leaves the core in charge of the pins
        if (ir_reg == tbsd_pkg::OP_EXTEST) begin
          pout_reg[i] <= upd_reg[2*i+1];
          poe_reg[i]  <= upd_reg[2*i];
        end else begin
          pout_reg[i] <= core_out_i[i];
          poe_reg[i]  <= core_oe_i[i];
        end
      end
    end
  end

  assign pin_out_o    = pout_reg;
  assign pin_oe_o     = poe_reg & {PIN_N{~part_rst_o}};
  assign pullup_dis_o = pud_reg;

  // ==========================================================
  // axi4-lite slave
  logic        aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0]  wstrb_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        wr_go, wr_b0, wr_mbx, jtag_clr;
  logic [31:0] rd_val;
  logic        rd_hit;

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  assign wr_go  = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_b0  = wr_go & wstrb_reg[0];
  assign wr_mbx = wr_b0 & (awaddr_reg == tbsd_pkg::ADDR_MBX) & mbx_sel;
  assign jtag_clr = tck_rise & (st_reg == tbsd_pkg::ST_UPD_DR) & (ir_reg == tbsd_pkg::OP_MBX);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bresp_reg   <= tbsd_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (awaddr_reg == tbsd_pkg::ADDR_MBX || awaddr_reg == tbsd_pkg::ADDR_CTRL ||
                        awaddr_reg == tbsd_pkg::ADDR_FUSE) ? tbsd_pkg::RESP_OKAY : tbsd_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // register writes and mailbox flag
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_dis_reg   <= 1'b0;
      dbg_fuse_reg  <= 1'b0;
      erased_reg    <= 1'b0;
      mbx_data_reg  <= '0;
      io_shared_reg <= '0;
      dirty_reg     <= 1'b0;
    end else if (ce_i) begin
      if (wr_b0 && awaddr_reg == tbsd_pkg::ADDR_MBX && !mbx_sel) begin
        io_shared_reg <= wdata_reg[7:0];
      end
      if (wr_mbx) begin
        mbx_data_reg <= wdata_reg[7:0];
      end
      // a cpu write in the clear cycle keeps the flag set
      if (wr_mbx) begin
        dirty_reg <= 1'b1;
      end else if (jtag_clr) begin
        dirty_reg <= 1'b0;
      end
      if (wr_b0 && awaddr_reg == tbsd_pkg::ADDR_CTRL) begin
        tap_dis_reg <= wdata_reg[tbsd_pkg::CTRL_TAP_DIS];
      end
      if (wr_b0 && awaddr_reg == tbsd_pkg::ADDR_FUSE) begin
        if (wdata_reg[tbsd_pkg::FUSE_ERASE]) begin
          erased_reg   <= 1'b1;
          dbg_fuse_reg <= 1'b0;
        end else if (wdata_reg[tbsd_pkg::FUSE_DBG_EN] && (!locked || erased_reg)) begin
          dbg_fuse_reg <= 1'b1;
        end
      end
    end
  end

  // debugger access enable, written through its own scan opcode
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dbg_acc_reg <= 1'b0;
    end else if (ce_i && tck_rise && st_reg == tbsd_pkg::ST_UPD_DR) begin
      if (ir_reg == tbsd_pkg::OP_DBGACC) begin
        dbg_acc_reg <= dr_sh_reg[0];
      end
    end
  end

  // ==========================================================
  // read path
  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      tbsd_pkg::ADDR_MBX:  rd_val[7:0] = mbx_sel ? {dirty_reg, mbx_data_reg[6:0]} : io_shared_reg;
      tbsd_pkg::ADDR_CTRL: rd_val[tbsd_pkg::CTRL_TAP_DIS] = tap_dis_reg;
      tbsd_pkg::ADDR_FUSE: begin
        rd_val[tbsd_pkg::FUSE_TAP_EN]  = tap_enable_fuse_i;
        rd_val[tbsd_pkg::FUSE_DBG_EN]  = dbg_fuse_reg;
        rd_val[tbsd_pkg::FUSE_ERASE]   = erased_reg;
        rd_val[tbsd_pkg::FUSE_LOCK1]   = lock_bit_one_i;
        rd_val[tbsd_pkg::FUSE_LOCK2]   = lock_bit_two_i;
        rd_val[tbsd_pkg::FUSE_DBG_ACC] = dbg_acc_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= tbsd_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && !rvalid_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_val;
        rresp_reg  <= rd_hit ? tbsd_pkg::RESP_OKAY : tbsd_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule

// ==== hw/tbsd_pkg.sv ====
// tbsd_pkg: constants and types for the tap boundary scan data path.
// assumes a single 200 MHz system clock samples all tap pins.
package tbsd_pkg;

  // ==========================================================
  // instruction opcodes
  localparam logic [3:0] OP_EXTEST  = 4'h0;
  localparam logic [3:0] OP_IDCODE  = 4'h1;
  localparam logic [3:0] OP_SAMPLE  = 4'h2;
  localparam logic [3:0] OP_MBX     = 4'h8;
  localparam logic [3:0] OP_DBGACC  = 4'h9;
  localparam logic [3:0] OP_RESET   = 4'hC;
  localparam logic [3:0] OP_BYPASS  = 4'hF;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ==========================================================
  // widths
  localparam int IR_W   = 4;
  localparam int ID_W   = 32;
  localparam int MBX_W  = 9;
  localparam int SYNC_N = 3;

  // ==========================================================
  // register map
  localparam logic [11:0] ADDR_MBX  = 12'h000;
  localparam logic [11:0] ADDR_CTRL = 12'h004;
  localparam logic [11:0] ADDR_FUSE = 12'h008;
  localparam int CTRL_TAP_DIS  = 7;
  localparam int FUSE_TAP_EN   = 0;
  localparam int FUSE_DBG_EN   = 1;
  localparam int FUSE_ERASE    = 2;
  localparam int FUSE_LOCK1    = 3;
  localparam int FUSE_LOCK2    = 4;
  localparam int FUSE_DBG_ACC  = 5;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // reset time-out defaults, in system clock cycles
  localparam int unsigned TMO_FAST_CYC = 32'd1000;
  localparam int unsigned TMO_SLOW_CYC = 32'd65536;

  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } tbsd_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tbsd_tap_pins_t;

  typedef struct packed {
    logic [3:0]  version;
    logic [15:0] part;
    logic [10:0] manuf;
    logic        one;
  } tbsd_idcode_t;

endpackage

// ==== verification/tbsd_monitor.sv ====
// tbsd_monitor: port checks for tbsd_top
// assumes a bind into tbsd_top with a short time-out
`timescale 1ns/1ps
module tbsd_monitor #(
  parameter int PIN_N = 28
) (
  // clock, reset, inputs
  input wire logic             clock_i,
  input wire logic             rst_n_i,
  input wire logic             tap_enable_fuse_i,
  input wire logic             ext_rst_n_i,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_rready,
  input wire logic             s_axi_bready,
  // outputs
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_bvalid,
  input wire logic             tdo_oe_o,
  input wire logic             part_rst_o,
  input wire logic [PIN_N-1:0] pin_oe_o
);
  // ==========================================
  // properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_float; part_rst_o |-> pin_oe_o == '0; endproperty
  property p_tapoff; !tap_enable_fuse_i [*8] |-> !tdo_oe_o; endproperty
  property p_extrst; !ext_rst_n_i [*5] |-> part_rst_o; endproperty
  property p_tmo; $rose(ext_rst_n_i) |-> part_rst_o [*8]; endproperty
  property p_wdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready; endproperty
  a_float: assert property (p_float) else $error("pins driven in reset");
  a_tapoff: assert property (p_tapoff) else $error("tdo driven while off");
  a_extrst: assert property (p_extrst) else $error("pin reset lost");
  a_tmo: assert property (p_tmo) else $error("time-out too short");
  a_wdone: assert property (p_wdone) else $error("write answer stuck");
  a_rhold: assert property (p_rhold) else $error("read answer moved");
  a_rlat: assert property (p_rlat) else $error("read answer late");
  a_rdone: assert property (p_rdone) else $error("read answer stuck");
  c_rst: cover property ($rose(part_rst_o));
  c_shift: cover property (tdo_oe_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind tbsd_top tbsd_monitor #(.PIN_N(PIN_N)) i_mon (.*);

// ==== verification/tbsd_jtag_host.sv ====
// tbsd_jtag_host: behavioural tap controller on the far side
// assumes tdo settles within half a 125 ns tck period
`timescale 1ns/1ps
module tbsd_jtag_host (
  // tap wires
  output tbsd_pkg::tbsd_tap_pins_t tap_o,
  input  wire logic                tdo_i
);
  initial tap_o = '0;
  // ==========================================
  // tck idles low outside frames
  task automatic step(input logic ms, input logic di, output logic q);
    tap_o.tms = ms;
    tap_o.tdi = di;
    #62.5;
    q = tdo_i;
    tap_o.tck = 1'b1;
    #62.5;
    tap_o.tck = 1'b0;
    tap_o.tdi = ~di; // stale data must not look valid
  endtask
  task automatic scan(input logic ir, input logic [31:0] v, input int n, output logic [31:0] q);
    logic b;
    q = '0;
    step(1'b1, 1'b0, b);
    if (ir) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask
endmodule

// ==== verification/tap_boundary_scan_datapath_tb_top.sv ====
// tap_boundary_scan_datapath_tb_top: bench for tbsd_top
// assumes tbsd_jtag_host and tbsd_monitor compiled first
`timescale 1ns/1ps
module tap_boundary_scan_datapath_tb_top;
  typedef struct packed {
    logic [3:0]  op;
    logic [3:0]  pi;
    logic [31:0] din;
    logic [5:0]  n;
    logic [31:0] exp;
    logic [3:0]  oe;
    logic [3:0]  po;
  } tbsd_row_t;
  localparam logic [31:0] ID = {4'h0, 16'h5A5A, 11'h155, 1'h1};
  // preload row precedes extest so pins never see junk
  localparam tbsd_row_t ROWS [5] = '{
    '{tbsd_pkg::OP_IDCODE, 4'h5, 32'h0, 6'h20, ID, 4'h0, 4'h3},
    '{tbsd_pkg::OP_BYPASS, 4'h5, 32'h1, 6'h2, 32'h2, 4'h0, 4'h3},
    '{4'h3, 4'h5, 32'h1, 6'h2, 32'h2, 4'h0, 4'h3},
    '{tbsd_pkg::OP_SAMPLE, 4'h5, 32'hFF, 6'h8, 32'h22, 4'h0, 4'h3},
    '{tbsd_pkg::OP_EXTEST, 4'hA, 32'h0, 6'h8, 32'h88, 4'hF, 4'hF}};
  logic clock_i = 0, rst_n_i = 0, ce_i = 1, tap_enable_fuse_i = 1, ext_rst_n_i = 1;
  logic lock_bit_one_i = 0, lock_bit_two_i = 0, clk_opt_slow_i = 0, oe_seen = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d, rv;
  logic [3:0] s_axi_wstrb = 4'hF, pin_in_i = 4'h5, core_out_i = 4'h3, core_oe_i = 0, pin_out_o, pin_oe_o;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tdo_o, tdo_oe_o, part_rst_o, pullup_dis_o;
  tbsd_pkg::tbsd_tap_pins_t tap_i;
  int fail_count = 0, checks_done = 0;
  tbsd_top #(.PIN_N(4), .TMO_FAST(8), .TMO_SLOW(16)) i_dut (.*);
  // a released tdo reads inverted: the link has no pull-up
  tbsd_jtag_host i_host (.tap_o(tap_i), .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o));
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) if (tdo_oe_o) oe_seen <= 1'b1;
  // ==========================================
  // tasks
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  // rready lags one cycle so a stalled answer is seen
  task automatic rd(input logic [11:0] a);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // ==========================================
  // sequence
  initial begin
    #400us;
    fail_count++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    chk(part_rst_o === 1'b1, "early release");
    i_host.reset_tap();
    for (int k = 0; k < 5; k++) begin
      @(posedge clock_i) pin_in_i <= ROWS[k].pi;
      i_host.scan(1'b1, {28'h0, ROWS[k].op}, 4, d);
      chk(d[3:0] === tbsd_pkg::IR_CAPTURE, "ir capture");
      chk({pin_oe_o, pin_out_o, pullup_dis_o} ===
          {ROWS[k].oe, ROWS[k].po, ROWS[k].op inside {4'h0, 4'h2}}, "pins");
      i_host.scan(1'b0, ROWS[k].din, int'(ROWS[k].n), d);
      chk(d === ROWS[k].exp, "data register");
    end
    @(posedge clock_i) core_oe_i <= 4'hF;
    i_host.scan(1'b1, 32'hC, 4, d);
    i_host.scan(1'b0, 32'h1, 1, d);
    chk(part_rst_o === 1'b1 && pin_oe_o === 4'h0, "reset bit");
    i_host.scan(1'b0, 32'h0, 1, d);
    chk(d[0] === 1'b1 && part_rst_o === 1'b0 && pin_oe_o === 4'hF, "reset release");
    @(posedge clock_i) ext_rst_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    ext_rst_n_i <= 1'b1;
    repeat (10) @(posedge clock_i);
    chk(part_rst_o === 1'b1, "time-out");
    repeat (4) @(posedge clock_i);
    chk(part_rst_o === 1'b0, "time-out end");
    clk_opt_slow_i <= 1'b1;
    ext_rst_n_i <= 1'b0;
    repeat (6) @(posedge clock_i);
    ext_rst_n_i <= 1'b1;
    repeat (18) @(posedge clock_i);
    chk(part_rst_o === 1'b1, "slow time-out");
    repeat (4) @(posedge clock_i);
    chk(part_rst_o === 1'b0, "slow time-out end");
    clk_opt_slow_i <= 1'b0;
    lock_bit_two_i <= 1'b1;
    wr(tbsd_pkg::ADDR_FUSE, 32'h2);
    rd(tbsd_pkg::ADDR_FUSE);
    chk(rv[1] === 1'b0 && rsp === tbsd_pkg::RESP_OKAY, "locked fuse");
    wr(tbsd_pkg::ADDR_FUSE, 32'h4);
    wr(tbsd_pkg::ADDR_FUSE, 32'h2);
    rd(tbsd_pkg::ADDR_FUSE);
    chk(rv[1] === 1'b1, "erased fuse");
    @(posedge clock_i) lock_bit_two_i <= 1'b0;
    wr(tbsd_pkg::ADDR_MBX, 32'h85);
    rd(tbsd_pkg::ADDR_MBX);
    chk(rv[7:0] === 8'h85, "plain io");
    i_host.scan(1'b1, 32'h9, 4, d);
    i_host.scan(1'b0, 32'h1, 1, d);
    wr(tbsd_pkg::ADDR_MBX, 32'h03);
    rd(tbsd_pkg::ADDR_MBX);
    chk(rv[7:0] === 8'h83, "mailbox dirty");
    i_host.scan(1'b1, 32'h8, 4, d);
    i_host.scan(1'b0, 32'h0, 9, d);
    rd(tbsd_pkg::ADDR_MBX);
    chk(d[8:0] === 9'h103 && rv[7:0] === 8'h03, "debugger read");
    rd(12'h0FC);
    chk(rsp === tbsd_pkg::RESP_SLVERR, "unmapped read");
    wr(12'h0FC, 32'h1);
    chk(rsp === tbsd_pkg::RESP_SLVERR, "unmapped write");
    wr(tbsd_pkg::ADDR_CTRL, 32'h80);
    chk(rsp === tbsd_pkg::RESP_OKAY, "ctrl write");
    rd(tbsd_pkg::ADDR_CTRL);
    chk(rv === 32'h80 && oe_seen === 1'b1, "ctrl readback");
    oe_seen = 1'b0;
    i_host.scan(1'b0, 32'h0, 32, d);
    // fuse alone must keep the port quiet too
    @(posedge clock_i) tap_enable_fuse_i <= 1'b0;
    wr(tbsd_pkg::ADDR_CTRL, 32'h0);
    i_host.scan(1'b0, 32'h0, 32, d);
    @(posedge clock_i) tap_enable_fuse_i <= 1'b1;
    chk(oe_seen === 1'b0, "tap disabled");
    i_host.reset_tap();
    i_host.scan(1'b0, 32'h0, 32, d);
    chk(d === ID, "tap enabled");
    end_sim();
  end
endmodule
